// file: core/acsp_pkg.sv
package acsp_pkg;

  // ==========================================================
  // Serial word layout and register map of the device.
  localparam int WORD_BITS = 16;
  localparam int REG_COUNT = 256;
  localparam logic [7:0] ADDR_GENERAL = 8'h00;
  localparam logic [7:0] ADDR_MODES = 8'h14;
  localparam logic [7:0] ADDR_FORMAT = 8'h16;
  localparam logic [7:0] REG_RESET_VALUE = 8'h00;
  localparam int BIT_READOUT = 0;
  localparam int BIT_SOFT_RST = 1;
  localparam int BIT_OVERRIDE = 7;
  localparam int BIT_IFACE_CMOS = 5;
  localparam int BIT_COARSE_GAIN = 4;
  localparam int BIT_EXT_REF = 3;
  localparam int BIT_STRAIGHT_BIN = 4;
  localparam int SYNC_W = 11;

  // ==========================================================
  // Timing at a 20 ns system clock.
  localparam int CLOCK_NS = 20;
  localparam int RESET_PULSE_NS = 10;
  localparam int RESET_PULSE_RAW = (RESET_PULSE_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int RESET_PULSE_CYC = (RESET_PULSE_RAW < 1) ? 1 : RESET_PULSE_RAW;
  localparam int SCLK_HALF_NS = 80;
  localparam int SCLK_HALF_CYC = SCLK_HALF_NS / CLOCK_NS;

  // ==========================================================
  // Controller register map on AXI4-Lite.
  localparam logic [7:0] CTRL_CMD = 8'h00;
  localparam logic [7:0] CTRL_STATUS = 8'h04;
  localparam logic [7:0] CTRL_PINS = 8'h08;
  localparam int CMD_KEEP_OPEN = 16;
  localparam int CMD_CLOSE = 17;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [8:0] PINS_RESET_VALUE = 9'h000;

  // Effective configuration presented by the device.
  typedef struct packed {
    logic gain_3p5db;
    logic ext_ref;
    logic straight_binary;
    logic cmos_if;
    logic chan_a_dis;
    logic chan_b_dis;
    logic power_down;
    logic chan_a_standby;
    logic chan_b_standby;
    logic mux_mode;
  } acsp_cfg_s;

  // Decodes a three-bit mode code, first pin as the most significant bit.
  function automatic acsp_cfg_s acsp_decode_modes(input logic [2:0] code,
                                                  input acsp_cfg_s base);
    acsp_cfg_s c;
    c = base;
    c.chan_a_dis = (code == 3'h1) || (code == 3'h3);
    c.chan_b_dis = (code == 3'h2) || (code == 3'h3);
    c.power_down = (code == 3'h4);
    c.chan_a_standby = (code == 3'h5);
    c.chan_b_standby = (code == 3'h6);
    c.mux_mode = (code == 3'h7);
    return c;
  endfunction

endpackage

// file: core/acsp_if.sv
`timescale 1ns/100ps
interface acsp_if;
  logic serial_select_n;
  logic shift_clock;
  logic serial_in_line;
  logic serial_out_line;
  logic reset_pin;
  logic mode_pin_1;
  logic mode_pin_2;
  logic mode_pin_3;
  logic [1:0] clock_level;
  logic [1:0] select_level;

  modport device (
    input serial_select_n, shift_clock, serial_in_line, reset_pin,
    input mode_pin_1, mode_pin_2, mode_pin_3, clock_level, select_level,
    output serial_out_line
  );

  modport controller (
    output serial_select_n, shift_clock, serial_in_line, reset_pin,
    output mode_pin_1, mode_pin_2, mode_pin_3, clock_level, select_level,
    input serial_out_line
  );
endinterface

// file: core/acsp_sync.sv
`timescale 1ns/100ps
module acsp_sync
#(
  parameter int WIDTH = 1
)
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  // ==========================================================
  // Two flip-flops per bit; only the second stage is visible.
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      stage1 <= '0;
      sync_out <= '0;
    end
    else if (ce)
    begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule

// file: core/acsp_device.sv
// Functional notes
// - Shift in only while select is low.
// - Sample data on shift clock falling edges.
// - Commit word on every sixteenth falling edge.
// - Leftover bits after last word ignored.
// - Several words per select period allowed.
// - Word is address byte then data byte.
// - Shift clock at most 20 MHz.
// - Controller resets registers before use; acsp_ctrl leaves the reset pin or soft reset to software.
// - Reset pin pulse restores register defaults.
// - Soft reset bit restores defaults, self-clears.
// - Readback mode blocks register writes.
// - Readback shifts addressed register data out.
// - Controller captures readback on falling edge.
// - Clearing readback bit re-enables writes.
// - Readback only with single-ended interface.
// - Serial output always driven, never floating.
// - Strap: clock pin selects gain, reference.
// - Strap: select pin selects format, interface.
// - Mode pins decode power and output states.
// - All mode pins high: multiplexed mode.
// - Controller holds reset low for serial; acsp_ctrl sends words whatever the reset pin is.
`timescale 1ns/100ps
module acsp_device
  import acsp_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic ce,
  acsp_if.device link,
  input wire logic output_clock_negative,
  output acsp_cfg_s cfg,
  output logic readback_active
);
  logic [SYNC_W-1:0] s_all;
  logic s_sclk;
  logic s_sel_n;
  logic s_sdi;
  logic s_rst;
  logic [2:0] s_mode;
  logic [1:0] s_clvl;
  logic [1:0] s_slvl;
  logic sclk_d;
  logic sdi_d;
  logic fall;
  logic [3:0] bit_cnt;
  logic [14:0] shift_in;
  logic [15:0] word;
  logic commit;
  logic [7:0] word_addr;
  logic [7:0] word_data;
  logic readout;
  logic write_ok;
  logic soft_rst;
  logic [1:0] rst_cnt;
  logic hw_rst;
  logic [7:0] out_shift;
  logic [7:0] regs [REG_COUNT];
  acsp_cfg_s reg_cfg;
  acsp_cfg_s strap_cfg;
  acsp_cfg_s zero_cfg;

  // ==========================================================
  // Input synchronisation
  // Every pin passes two flip-flops before any logic sees it.
  acsp_sync #(.WIDTH(SYNC_W)) u_sync (
    .clock(clock),
    .nrst(nrst),
    .ce(ce),
    .async_in({link.shift_clock, link.serial_select_n, link.serial_in_line,
               link.reset_pin, link.mode_pin_1, link.mode_pin_2,
               link.mode_pin_3, link.clock_level, link.select_level}),
    .sync_out(s_all)
  );

  assign {s_sclk, s_sel_n, s_sdi, s_rst, s_mode, s_clvl, s_slvl} = s_all;

  // Delayed copies used to find the shift clock falling edge.
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      sclk_d <= 1'b0;
      sdi_d <= 1'b0;
    end
    else if (ce)
    begin
      sclk_d <= s_sclk;
      sdi_d <= s_sdi;
    end
  end

  // ==========================================================
  // Serial shift and word framing
  // Data is taken from the cycle before the edge so a data change
  // made together with the falling edge is not mistaken for the bit.
  assign fall = sclk_d && !s_sclk && !s_sel_n;
  assign word = {shift_in, sdi_d};
  assign commit = fall && (bit_cnt == 4'hf);
  assign word_addr = word[15:8];
  assign word_data = word[7:0];
  assign readout = regs[ADDR_GENERAL][BIT_READOUT];

  // Bit counter wraps at sixteen so words may follow back to back.
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      bit_cnt <= 4'h0;
      shift_in <= 15'h0000;
    end
    else if (ce)
    begin
      if (s_sel_n)
      begin
        bit_cnt <= 4'h0;
      end
      else if (fall)
      begin
        bit_cnt <= bit_cnt + 4'h1;
        shift_in <= word[14:0];
      end
    end
  end

  // ==========================================================
  // Register file and its resets
  // A high level on the reset pin clears in its first cycle, as the minimum count is one.
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      rst_cnt <= 2'h0;
    end
    else if (ce)
    begin
      if (!s_rst)
      begin
        rst_cnt <= 2'h0;
      end
      else if (rst_cnt != 2'h3)
      begin
        rst_cnt <= rst_cnt + 2'h1;
      end
    end
  end

  assign hw_rst = s_rst && (rst_cnt >= 2'(RESET_PULSE_CYC - 1));

  // The general register stays writable so readback can be left.
  assign write_ok = commit && (!readout || word_addr == ADDR_GENERAL);
  assign soft_rst = write_ok && (word_addr == ADDR_GENERAL) && word_data[BIT_SOFT_RST];

  // Writes store the data byte; the soft reset bit is never kept.
  always_ff @(posedge clock)
  begin
    if (!nrst || (ce && (hw_rst || soft_rst)))
    begin
      for (int i = 0; i < REG_COUNT; i++)
      begin
        regs[i] <= REG_RESET_VALUE;
      end
    end
    else if (ce && write_ok)
    begin
      regs[word_addr] <= (word_addr == ADDR_GENERAL) ?
                         (word_data & ~(8'h01 << BIT_SOFT_RST)) : word_data;
    end
  end

  // ==========================================================
  // Readback shifter
  // The addressed byte loads after the eighth bit, then one bit leaves
  // per falling edge, so the controller sees each bit at the next fall.
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      out_shift <= 8'h00;
    end
    else if (ce)
    begin
      if (s_sel_n || !readout)
      begin
        out_shift <= 8'h00;
      end
      else if (fall && bit_cnt == 4'h7)
      begin
        out_shift <= regs[word[7:0]];
      end
      else if (fall && bit_cnt == 4'hf)
      begin
        out_shift <= 8'h00;
      end
      else if (fall && bit_cnt[3])
      begin
        out_shift <= {out_shift[6:0], 1'b0};
      end
    end
  end

  // Serial output: clock in differential mode, else readback or low.
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      link.serial_out_line <= 1'b0;
      readback_active <= 1'b0;
    end
    else if (ce)
    begin
      readback_active <= readout && cfg.cmos_if;
      if (!cfg.cmos_if)
      begin
        link.serial_out_line <= output_clock_negative;
      end
      else
      begin
        link.serial_out_line <= readout ? out_shift[7] : 1'b0;
      end
    end
  end

  // ==========================================================
  // Configuration decode
  // Register view: power modes follow the pins unless overridden.
  always_comb
  begin
    zero_cfg = '0;
    reg_cfg = zero_cfg;
    reg_cfg.gain_3p5db = regs[ADDR_MODES][BIT_COARSE_GAIN];
    reg_cfg.ext_ref = regs[ADDR_MODES][BIT_EXT_REF];
    reg_cfg.cmos_if = regs[ADDR_MODES][BIT_IFACE_CMOS];
    reg_cfg.straight_binary = regs[ADDR_FORMAT][BIT_STRAIGHT_BIN];
    reg_cfg = acsp_decode_modes(regs[ADDR_MODES][BIT_OVERRIDE] ?
                                regs[ADDR_MODES][2:0] : s_mode, reg_cfg);
  end

  // Strap view: four-level codes counted upward from ground.
  always_comb
  begin
    strap_cfg = '0;
    strap_cfg.gain_3p5db = s_clvl[1];
    strap_cfg.ext_ref = (s_clvl == 2'h1) || (s_clvl == 2'h2);
    strap_cfg.straight_binary = (s_slvl == 2'h1) || (s_slvl == 2'h2);
    strap_cfg.cmos_if = s_slvl[1];
    strap_cfg = acsp_decode_modes(s_mode, strap_cfg);
  end

  // A reset pin held high selects strap control.
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      cfg <= '0;
    end
    else if (ce)
    begin
      cfg <= s_rst ? strap_cfg : reg_cfg;
    end
  end
endmodule

// file: core/acsp_ctrl.sv
// Our own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module acsp_ctrl
  import acsp_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  acsp_if.controller link
);
  typedef enum logic [2:0] {ST_IDLE, ST_LOW, ST_HIGH, ST_OPEN, ST_END} acsp_state_e;

  acsp_state_e state;
  logic s_sdo;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic aw_got;
  logic w_got;
  logic do_write;
  logic cmd_hit;
  logic start;
  logic close;
  logic busy;
  logic [15:0] word;
  logic keep_open;
  logic [3:0] bit_cnt;
  logic [2:0] div;
  logic div_done;
  logic [7:0] rd_data;
  logic [8:0] pins;

  // ==========================================================
  // Readback line enters through two flip-flops.
  acsp_sync #(.WIDTH(1)) u_sync (
    .clock(clock),
    .nrst(nrst),
    .ce(ce),
    .async_in(link.serial_out_line),
    .sync_out(s_sdo)
  );

  // ==========================================================
  // AXI4-Lite write channels, taken in either order.
  assign do_write = aw_got && w_got && !s_axi_bvalid;
  assign busy = (state != ST_IDLE) && (state != ST_OPEN);
  assign cmd_hit = do_write && (aw_addr == CTRL_CMD) && (&w_strb[2:0]);
  assign start = cmd_hit && !busy && !w_data[CMD_CLOSE];
  assign close = cmd_hit && (state == ST_OPEN) && w_data[CMD_CLOSE];

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write)
      begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr == CTRL_PINS || (aw_addr == CTRL_CMD && !(busy && !w_data[CMD_CLOSE])))
        begin
          s_axi_bresp <= RESP_OKAY;
        end
        else
        begin
          s_axi_bresp <= RESP_SLVERR;
        end
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Pin register: reset pin low by default, pulsed only by software.
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      pins <= PINS_RESET_VALUE;
    end
    else if (ce && do_write && aw_addr == CTRL_PINS)
    begin
      if (w_strb[0])
      begin
        pins[7:0] <= w_data[7:0];
      end
      if (w_strb[1])
      begin
        pins[8] <= w_data[8];
      end
    end
  end

  // Mode pins and level codes follow the pin register.
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      link.reset_pin <= 1'b0;
      {link.mode_pin_1, link.mode_pin_2, link.mode_pin_3} <= 3'h0;
      link.clock_level <= 2'h0;
      link.select_level <= 2'h0;
    end
    else if (ce)
    begin
      link.reset_pin <= pins[0];
      {link.mode_pin_1, link.mode_pin_2, link.mode_pin_3} <= pins[3:1];
      link.clock_level <= pins[5:4];
      link.select_level <= pins[7:6];
    end
  end

  // ==========================================================
  // AXI4-Lite read channel.
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        unique case (s_axi_araddr)
          CTRL_CMD: s_axi_rdata <= {14'h0000, keep_open, 1'b0, word};
          CTRL_STATUS: s_axi_rdata <= {16'h0000, rd_data, 6'h00, state == ST_OPEN, busy};
          CTRL_PINS: s_axi_rdata <= {23'h000000, pins};
          default:
          begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Serial engine: the shift clock comes from a divider.
  assign div_done = (div == 3'(SCLK_HALF_CYC - 1));

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      state <= ST_IDLE;
      div <= 3'h0;
      bit_cnt <= 4'h0;
      word <= 16'h0000;
      keep_open <= 1'b0;
      rd_data <= 8'h00;
      link.serial_select_n <= 1'b1;
      link.shift_clock <= 1'b0;
      link.serial_in_line <= 1'b0;
    end
    else if (ce)
    begin
      div <= div_done ? 3'h0 : div + 3'h1;
      unique case (state)
        ST_IDLE, ST_OPEN:
        begin
          div <= 3'h0;
          if (start)
          begin
            word <= w_data[15:0];
            keep_open <= w_data[CMD_KEEP_OPEN];
            bit_cnt <= 4'h0;
            link.serial_select_n <= 1'b0;
            link.serial_in_line <= w_data[15];
            state <= ST_LOW;
          end
          else if (close)
          begin
            state <= ST_END;
          end
        end
        ST_LOW:
        begin
          if (div_done)
          begin
            link.shift_clock <= 1'b1;
            state <= ST_HIGH;
          end
        end
        ST_HIGH:
        begin
          if (div_done)
          begin
            link.shift_clock <= 1'b0;
            word <= {word[14:0], 1'b0};
            link.serial_in_line <= word[14];
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt[3])
            begin
              rd_data <= {rd_data[6:0], s_sdo};
            end
            if (bit_cnt == 4'hf)
            begin
              state <= keep_open ? ST_OPEN : ST_END;
            end
            else
            begin
              state <= ST_LOW;
            end
          end
        end
        ST_END:
        begin
          if (div_done)
          begin
            link.serial_select_n <= 1'b1;
            link.serial_in_line <= 1'b0;
            state <= ST_IDLE;
          end
        end
      endcase
    end
  end
endmodule

// file: tb/acsp_link_props.sv
`timescale 1ns/100ps
module acsp_link_props
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic serial_select_n,
  input wire logic shift_clock,
  input wire logic serial_in_line,
  input wire logic reset_pin
);
  // ========
  // Fall counting.
  logic sclk_q;
  logic [15:0] falls;

  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);

  // Keeps the last sample of the shift clock.
  always_ff @(posedge clock)
  begin
    sclk_q <= shift_clock;
  end

  // Counts shift clock falls while select is low.
  always_ff @(posedge clock)
  begin
    if (!nrst || serial_select_n)
    begin
      falls <= 16'h0000;
    end
    else if (sclk_q && !shift_clock)
    begin
      falls <= falls + 16'h0001;
    end
  end

  // ========
  // Link properties.
  chk_idle_clock_low: assert property (serial_select_n |-> !shift_clock)
    else $error("shift clock high while deselected");
  chk_select_setup: assert property ($fell(serial_select_n) |-> !shift_clock [*4])
    else $error("shift clock rose too soon after select");
  chk_high_phase: assert property ($rose(shift_clock) |-> shift_clock [*4] ##1 !shift_clock)
    else $error("shift clock high phase wrong");
  chk_low_phase: assert property ($fell(shift_clock) |-> !shift_clock [*4])
    else $error("shift clock low phase too short");
  chk_data_held_high: assert property ($rose(shift_clock) |-> $stable(serial_in_line) [*4])
    else $error("serial data moved during high phase");
  chk_whole_words: assert property ($rose(serial_select_n) |->
    falls[3:0] == 4'h0 && falls != 16'h0000)
    else $error("select period not a whole number of words");
  chk_reset_low_serial: assert property (!serial_select_n |-> !reset_pin)
    else $error("reset pin high during serial access");
  chk_select_hold: assert property ($rose(serial_select_n) |-> !$past(shift_clock, 3))
    else $error("select rose too soon after last fall");

  // Main scenarios reached.
  cover property ($rose(serial_select_n) && falls == 16'h0020);
  cover property ($rose(reset_pin));
  cover property ($fell(serial_select_n));
endmodule

// file: tb/tb_adc_config_serial_port.sv
`timescale 1ns/100ps
module tb_adc_config_serial_port
  import acsp_pkg::*;
();
  // ========
  // Stimulus and model state.
  logic clock;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic ocn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, rb_act;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, s;
  logic [1:0] r;
  acsp_cfg_s cfg, cfg2;
  int miscompares = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [7:0] m_regs [256];
  logic [8:0] m_pins = 9'h000;
  acsp_if lk();
  acsp_if rg();

  acsp_ctrl acsp_ctrl_i (.clock(clock), .nrst(nrst), .ce(ce), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .link(lk.controller));
  acsp_device acsp_device_i (.clock(clock), .nrst(nrst), .ce(ce), .link(lk.device),
    .output_clock_negative(ocn), .cfg(cfg), .readback_active(rb_act));
  acsp_device rogue_acsp_device_i (.clock(clock), .nrst(nrst), .ce(ce), .link(rg.device),
    .output_clock_negative(ocn), .cfg(cfg2), .readback_active());
  acsp_link_props props_i (.clock(clock), .nrst(nrst), .serial_select_n(lk.serial_select_n),
    .shift_clock(lk.shift_clock), .serial_in_line(lk.serial_in_line), .reset_pin(lk.reset_pin));

  // Clock and hang guard.
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      miscompares++;
      conclude();
    end
  end

  // ========
  // Checking and bus tasks.
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic acsp_cfg_s mcfg();
    acsp_cfg_s c;
    logic [7:0] m;
    logic [2:0] k;
    c = '0;
    m = m_regs[8'h14];
    k = m[7] ? m[2:0] : m_pins[3:1];
    c.gain_3p5db = m_pins[0] ? m_pins[5] : m[4];
    c.ext_ref = m_pins[0] ? m_pins[5] ^ m_pins[4] : m[3];
    c.straight_binary = m_pins[0] ? m_pins[7] ^ m_pins[6] : m_regs[8'h16][4];
    c.cmos_if = m_pins[0] ? m_pins[7] : m[5];
    c.chan_a_dis = k == 3'h1 || k == 3'h3;
    c.chan_b_dis = k == 3'h2 || k == 3'h3;
    c.power_down = k == 3'h4;
    c.chan_a_standby = k == 3'h5;
    c.chan_b_standby = k == 3'h6;
    c.mux_mode = k == 3'h7;
    return c;
  endfunction
  task automatic cmp_cfg(input acsp_cfg_s g);
    cmp({22'h0, g}, {22'h0, mcfg()});
  endtask
  task automatic mclear();
    foreach (m_regs[i]) m_regs[i] = 8'h00;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever
    begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid)
      begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever
    begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid)
      begin
        s = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask
  // Sends one word and keeps the model in step with it.
  task automatic send(input logic [15:0] w, input logic k);
    int n;
    logic lock;
    lock = m_regs[0][0] && m_regs[8'h14][5];
    wr(CTRL_CMD, {15'h0, k, w});
    cmp(32'(r), 32'(RESP_OKAY));
    s = 32'h1;
    n = 0;
    while (s[0] && n < 200)
    begin
      rd(CTRL_STATUS);
      n++;
    end
    if (lock && w[15:8] != 8'h00)
      cmp(32'(s[15:8]), 32'(m_regs[w[15:8]]));
    else if (w[15:8] == 8'h00 && w[1])
      mclear();
    else if (!m_regs[0][0] || w[15:8] == 8'h00)
      m_regs[w[15:8]] = w[7:0];
  endtask
  task automatic pins(input logic [8:0] p);
    wr(CTRL_PINS, {23'h0, p});
    m_pins = p;
    if (p[0]) mclear();
    repeat (12) @(posedge clock);
  endtask
  // Second link driven by hand, one bit at 160 ns.
  task automatic rbit(input logic b);
    @(posedge clock);
    rg.serial_in_line <= b;
    repeat (3) @(posedge clock);
    rg.shift_clock <= 1'b1;
    repeat (4) @(posedge clock);
    rg.shift_clock <= 1'b0;
  endtask
  task automatic rframe(input logic [15:0] w, input int n);
    @(posedge clock);
    rg.serial_select_n <= 1'b0;
    for (int i = 15; i >= 0; i--) rbit(w[i]);
    for (int i = 0; i < n; i++) rbit(1'b1);
    repeat (4) @(posedge clock);
    rg.serial_select_n <= 1'b1;
    rg.serial_in_line <= ~rg.serial_in_line;
  endtask
  task automatic conclude();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ========
  // Main sequence.
  initial
  begin
    rg.serial_select_n = 1'b1;
    rg.shift_clock = 1'b0;
    rg.serial_in_line = 1'b0;
    rg.reset_pin = 1'b0;
    {rg.mode_pin_1, rg.mode_pin_2, rg.mode_pin_3} = 3'h0;
    rg.clock_level = 2'h0;
    rg.select_level = 2'h0;
    mclear();
    void'($urandom(91437));
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    cmp_cfg(cfg);
    cmp(32'(lk.serial_out_line), 32'h0);
    rd(8'h0c);
    cmp(32'(r), 32'(RESP_SLVERR));
    $display("test reset done");
    for (int i = 0; i < 8; i++)
    begin
      send({ADDR_MODES, 2'h2, 3'($urandom), 3'(i)}, 1'b0);
      cmp_cfg(cfg);
    end
    send({ADDR_FORMAT, 3'h0, 1'($urandom), 4'h0}, 1'b1);
    cmp(32'(s[1:0]), 32'h2);
    send({ADDR_MODES, 8'h20}, 1'b1);
    wr(CTRL_CMD, 32'h00020000);
    cmp(32'(r), 32'(RESP_OKAY));
    do rd(CTRL_STATUS); while (s[0]);
    cmp_cfg(cfg);
    for (int i = 0; i < 8; i++)
    begin
      pins({5'h0, 3'(i), 1'b0});
      cmp_cfg(cfg);
    end
    $display("test words and modes done");
    rframe({ADDR_MODES, 8'h30}, 7);
    rframe({ADDR_MODES, 8'hff}, 0);
    rg.shift_clock <= 1'b0;
    @(posedge clock);
    rg.serial_select_n <= 1'b0;
    for (int i = 0; i < 10; i++) rbit(1'b1);
    rg.serial_select_n <= 1'b1;
    rframe({ADDR_FORMAT, 8'h10}, 0);
    repeat (2) @(posedge clock);
    cmp({22'h0, cfg2}, 32'h3c1);
    $display("test loose bits done");
    send({ADDR_MODES, 8'h18}, 1'b0);
    send({ADDR_GENERAL, 8'h02}, 1'b0);
    cmp_cfg(cfg);
    send({ADDR_MODES, 8'h20}, 1'b0);
    send({ADDR_GENERAL, 8'h01}, 1'b0);
    cmp(32'(rb_act), 32'h1);
    send({ADDR_MODES, 8'h18}, 1'b0);
    send({ADDR_FORMAT, 8'h10}, 1'b0);
    cmp_cfg(cfg);
    send({ADDR_GENERAL, 8'h00}, 1'b0);
    send({ADDR_MODES, 8'h18}, 1'b0);
    cmp_cfg(cfg);
    send({ADDR_GENERAL, 8'h01}, 1'b0);
    cmp(32'(rb_act), 32'h0);
    for (int v = 1; v >= 0; v--)
    begin
      ocn <= 1'(v);
      repeat (6) @(posedge clock);
      cmp(32'(lk.serial_out_line), 32'(v));
    end
    send({ADDR_GENERAL, 8'h00}, 1'b0);
    $display("test readback done");
    for (int i = 0; i < 4; i++)
    begin
      pins({1'b0, 2'(i), 2'(3 - i), 3'(i), 1'b1});
      cmp_cfg(cfg);
    end
    pins(9'h000);
    cmp_cfg(cfg);
    rd(CTRL_PINS);
    cmp(s, {23'h0, m_pins});
    $display("test strap and reset pin done");
    conclude();
  end
endmodule
